// ===== ffc_defines.svh
// ffc_defines.svh: constants for the float format converter datapath.
// assumes inclusion by bare name from the package and the design files.
`ifndef FFC_DEFINES_SVH
`define FFC_DEFINES_SVH
`define FFC_WORD_W 32
`define FFC_EXP_W 8
`define FFC_FRAC_W 23
`define FFC_N_EXP_MSB 31
`define FFC_N_EXP_LSB 24
`define FFC_N_SIGN_BIT 23
`define FFC_I_SIGN_BIT 31
`define FFC_I_EXP_MSB 30
`define FFC_I_EXP_LSB 23
`define FFC_N_ZERO_EXP 8'h80
`define FFC_I_BIAS 8'h7F
`define FFC_I_EXP_MAX 8'hFF
`define FFC_N_EXP_MAX 8'h7F
`define FFC_N_ZERO_WORD 32'h80000000
`define FFC_N_POS_MAX 32'h7F7FFFFF
`define FFC_N_NEG_MAX 32'h7F800000
`define FFC_RESULT_RESET 32'h00000000
`endif

// ===== ffc_pkg.sv
// ffc_pkg.sv: operation and source types shared by the converter files.
// assumes ffc_defines.svh is on the include path.
`include "ffc_defines.svh"
package ffc_pkg;
  // one-hot operation codes issued by the pipeline
  typedef enum logic [4:0] {
    FFC_OP_NONE = 5'h01,
    FFC_OP_TO_STD = 5'h02,
    FFC_OP_FROM_STD = 5'h04,
    FFC_OP_MUL_SHI = 5'h08,
    FFC_OP_MUL_UHI = 5'h10
  } ffc_op_e;
  // where the source operand came from
  typedef enum logic [1:0] {
    FFC_SRC_MEMORY = 2'h1,
    FFC_SRC_EXTREG = 2'h2
  } ffc_src_e;
  typedef logic [`FFC_WORD_W-1:0] ffc_word_t;
endpackage

// ===== ffc_mul_high.sv
// ffc_mul_high.sv: combinational 32x32 multiplier returning the high product word.
// assumes the caller registers the result.
`timescale 1ns/1ns
module ffc_mul_high #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] op_a,
  input wire logic [WIDTH-1:0] op_b,
  input wire logic is_signed,
  output logic [WIDTH-1:0] high_word
);
  logic [2*WIDTH-1:0] prod_s;
  logic [2*WIDTH-1:0] prod_u;
  // both products formed; a mux picks signed or unsigned high half
  always_comb begin
    prod_s = (2*WIDTH)'($signed({{WIDTH{op_a[WIDTH-1]}}, op_a}) *
                      $signed({{WIDTH{op_b[WIDTH-1]}}, op_b}));
    prod_u = {{WIDTH{1'b0}}, op_a} * {{WIDTH{1'b0}}, op_b};
    high_word = is_signed ? prod_s[2*WIDTH-1:WIDTH] : prod_u[2*WIDTH-1:WIDTH];
  end
endmodule // ffc_mul_high

// ===== ffc_converter.sv
// ffc_converter.sv: float format converter and high-word multiplier datapath.
// assumes the pipeline presents one operation per cycle with its operands.
`timescale 1ns/1ns
`include "ffc_defines.svh"
module ffc_converter #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire ffc_pkg::ffc_op_e op,
  input wire ffc_pkg::ffc_src_e src,
  input wire logic [WIDTH-1:0] operand_a,
  input wire logic [WIDTH-1:0] operand_b,
  output logic [WIDTH-1:0] result,
  output logic result_valid,
  output logic source_error,
  output logic [3:0] std_class
);
  import ffc_pkg::*;

  logic [WIDTH-1:0] result_reg, result_next;
  logic valid_reg, valid_next;
  logic err_reg, err_next;
  logic [3:0] class_reg, class_next;
  logic [WIDTH-1:0] mul_high;

  // field views of the operand
  logic [7:0] n_exp, i_exp;
  logic n_sign, i_sign;
  logic [22:0] n_frac, i_frac;
  logic [7:0] n_exp_p1;
  logic [WIDTH-1:0] to_std, from_std;
  logic i_zero, i_denorm, i_inf, i_nan;

  ffc_mul_high #(.WIDTH(WIDTH)) u_mul (
    .op_a(operand_a),
    .op_b(operand_b),
    .is_signed(op == FFC_OP_MUL_SHI),
    .high_word(mul_high)
  );

  // native layout: exponent, sign, fraction
  assign n_exp = operand_a[`FFC_N_EXP_MSB:`FFC_N_EXP_LSB];
  assign n_sign = operand_a[`FFC_N_SIGN_BIT];
  assign n_frac = operand_a[`FFC_FRAC_W-1:0];
  // standard layout: sign, biased exponent, fraction
  assign i_sign = operand_a[`FFC_I_SIGN_BIT];
  assign i_exp = operand_a[`FFC_I_EXP_MSB:`FFC_I_EXP_LSB];
  assign i_frac = operand_a[`FFC_FRAC_W-1:0];
  assign n_exp_p1 = 8'(n_exp + 8'h01);

  // classify a standard word
  always_comb begin
    i_zero = (i_exp == 8'h00) && (i_frac == 23'h000000);
    i_denorm = (i_exp == 8'h00) && (i_frac != 23'h000000);
    i_inf = (i_exp == `FFC_I_EXP_MAX) && (i_frac == 23'h000000);
    i_nan = (i_exp == `FFC_I_EXP_MAX) && (i_frac != 23'h000000);
  end

  // native to standard: mantissa 01.f is positive 1.f, 10.f is -(2 - 0.f)
  // negative with f==0 is exactly -2, so it carries into the exponent
  always_comb begin
    logic [22:0] mag;
    logic [8:0] e_b;
    mag = 23'h000000;
    e_b = 9'h000;
    to_std = 32'h00000000;
    if (n_exp == `FFC_N_ZERO_EXP) begin
      to_std = 32'h00000000;
    end else if (!n_sign) begin
      e_b = 9'({n_exp[7], n_exp} + 9'h07F);
      to_std = {1'b0, e_b[7:0], n_frac};
    end else if (n_frac == 23'h000000) begin
      // value -2^(e+1); e=127 would overflow, saturate to largest magnitude
      e_b = 9'({n_exp_p1[7], n_exp_p1} + 9'h07F);
      to_std = (n_exp == `FFC_N_EXP_MAX) ? 32'hFF7FFFFF : {1'b1, e_b[7:0], 23'h000000};
    end else begin
      mag = 23'(~n_frac + 23'h000001);
      e_b = 9'({n_exp[7], n_exp} + 9'h07F);
      to_std = {1'b1, e_b[7:0], mag};
    end
    // exponents below -126 give a zero biased field; flush to zero
    if (n_exp != `FFC_N_ZERO_EXP && e_b[7:0] == 8'h00) begin
      to_std = 32'h00000000;
    end
  end

  // standard to native: negative 1.f becomes -(1.f) in twos complement
  always_comb begin
    logic [7:0] e_n;
    logic [23:0] neg_m;
    e_n = 8'(i_exp - `FFC_I_BIAS);
    neg_m = 24'(~{1'b1, i_frac} + 24'h000001);
    if (i_zero || i_denorm) begin
      from_std = `FFC_N_ZERO_WORD;
    end else if (i_inf || i_nan) begin
      from_std = i_sign ? `FFC_N_NEG_MAX : `FFC_N_POS_MAX;
    end else if (!i_sign) begin
      from_std = {e_n, 1'b0, i_frac};
    end else if (i_frac == 23'h000000) begin
      // -1.0 is 2^(e-1) * 10.0, one exponent lower
      from_std = (e_n == `FFC_N_ZERO_EXP) ? `FFC_N_ZERO_WORD :
                 {8'(e_n - 8'h01), 1'b1, 23'h000000};
    end else begin
      from_std = {e_n, 1'b1, neg_m[22:0]};
    end
  end

  // next-state for the result register; one cycle per operation
  always_comb begin
    result_next = result_reg;
    valid_next = 1'b0;
    err_next = 1'b0;
    class_next = class_reg;
    unique case (op)
      FFC_OP_NONE: begin
        result_next = result_reg;
      end
      FFC_OP_TO_STD: begin
        result_next = to_std;
        valid_next = 1'b1;
      end
      FFC_OP_FROM_STD: begin
        // standard-format source must come from memory
        if (src == FFC_SRC_MEMORY) begin
          result_next = from_std;
          valid_next = 1'b1;
          class_next = {i_nan, i_inf, i_denorm, i_zero};
        end else begin
          err_next = 1'b1;
        end
      end
      FFC_OP_MUL_SHI, FFC_OP_MUL_UHI: begin
        result_next = mul_high;
        valid_next = 1'b1;
      end
      default: begin
        err_next = 1'b1;
      end
    endcase
  end

  // register stage feeding the extended-precision register write port
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= `FFC_RESULT_RESET;
      valid_reg <= 1'b0;
      err_reg <= 1'b0;
      class_reg <= 4'h0;
    end else begin
      result_reg <= result_next;
      valid_reg <= valid_next;
      err_reg <= err_next;
      class_reg <= class_next;
    end
  end

  assign result = result_reg;
  assign result_valid = valid_reg;
  assign source_error = err_reg;
  assign std_class = class_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  conv_one_cycle_a: assert property ((op == FFC_OP_TO_STD) |=> result_valid)
    else $error("conversion not done in one cycle");
  zero_native_a: assert property ((op == FFC_OP_TO_STD && n_exp == 8'h80) |=>
    result == 32'h00000000) else $error("native zero not converted to zero");
  std_zero_map_a: assert property ((op == FFC_OP_FROM_STD && src == FFC_SRC_MEMORY &&
    i_exp == 8'h00) |=> result == 32'h80000000) else $error("zero or denormal map wrong");
  inf_nan_map_a: assert property ((op == FFC_OP_FROM_STD && src == FFC_SRC_MEMORY &&
    i_exp == 8'hFF && !i_sign) |=> result == 32'h7F7FFFFF) else $error("inf map wrong");
  src_check_a: assert property ((op == FFC_OP_FROM_STD && src != FFC_SRC_MEMORY) |=>
    (source_error && !result_valid)) else $error("register source accepted");
  mul_signed_a: assert property ((op == FFC_OP_MUL_SHI) |=> result ==
    32'(({{32{$past(operand_a[31])}}, $past(operand_a)} *
         {{32{$past(operand_b[31])}}, $past(operand_b)}) >> 32)) else $error("signed high wrong");
  mul_unsigned_a: assert property ((op == FFC_OP_MUL_UHI) |=> result ==
    32'(({32'h0, $past(operand_a)} * {32'h0, $past(operand_b)}) >> 32))
    else $error("unsigned high wrong");
  pos_native_a: assert property ((op == FFC_OP_TO_STD && n_exp == 8'h00 && !n_sign) |=>
    result == {9'h07F, $past(n_frac)}) else $error("positive mantissa wrong");
  class_nan_a: assert property ((op == FFC_OP_FROM_STD && src == FFC_SRC_MEMORY && i_nan)
    |=> std_class == 4'h8) else $error("nan not classified");
  idle_hold_a: assert property ((op == FFC_OP_NONE) |=> (!result_valid &&
    $stable(result))) else $error("idle changed result");
  // formats checked from their definitions, not from the datapath terms
  neg_native_a: assert property ((op == FFC_OP_TO_STD && n_exp == 8'h00 && n_sign &&
    n_frac != 23'h000000) |=> result == {9'h17F, 23'(~$past(n_frac) + 23'h000001)})
    else $error("negative mantissa wrong");
  neg_sat_map_a: assert property ((op == FFC_OP_FROM_STD && src == FFC_SRC_MEMORY &&
    i_exp == 8'hFF && i_sign) |=> result == 32'h7F800000) else $error("negative inf map wrong");
  class_low_a: assert property ((op == FFC_OP_FROM_STD && src == FFC_SRC_MEMORY &&
    i_exp == 8'h00) |=> std_class == {2'b00, $past(i_frac) != 23'h000000,
    $past(i_frac) == 23'h000000}) else $error("zero or denormal class wrong");
  class_hold_a: assert property ((op != FFC_OP_FROM_STD) |=> $stable(std_class))
    else $error("class changed without a standard operand");
  mul_valid_a: assert property ((op == FFC_OP_MUL_SHI || op == FFC_OP_MUL_UHI) |=>
    (result_valid && !source_error)) else $error("multiply not accepted");
  // an undecoded code must be flagged, never taken as an operation
  bad_op_a: assert property (!(op inside {FFC_OP_NONE, FFC_OP_TO_STD, FFC_OP_FROM_STD,
    FFC_OP_MUL_SHI, FFC_OP_MUL_UHI}) |=> (source_error && !result_valid))
    else $error("illegal operation accepted");

  to_std_c: cover property (op == FFC_OP_TO_STD ##1 op == FFC_OP_TO_STD);
  from_std_c: cover property (op == FFC_OP_FROM_STD && src == FFC_SRC_MEMORY && i_denorm);
  mul_c: cover property (op == FFC_OP_MUL_SHI ##1 op == FFC_OP_MUL_UHI);
  // a refused register source leaves the result alone, as idle and an undecoded code do
  refused_src_c: cover property (op == FFC_OP_FROM_STD && src == FFC_SRC_EXTREG);
endmodule // ffc_converter

// ===== test_float_format_converter.sv
// test_float_format_converter.sv: self-checking bench for the format converter datapath.
// assumes ffc_pkg and ffc_converter are compiled first; the bench drives every port itself.
`timescale 1ns/1ns
module test_float_format_converter;
  import ffc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ffc_op_e op = FFC_OP_NONE;
  ffc_src_e src = FFC_SRC_MEMORY;
  logic [31:0] operand_a = 32'h00000000;
  logic [31:0] operand_b = 32'h00000000;
  logic [31:0] result;
  logic result_valid;
  logic source_error;
  logic [3:0] std_class;
  int err_count = 0;
  int tests_run = 0;
  // hand-worked pairs: native word and its standard image, boundaries of the exponent included
  logic [31:0] nat_w[7] = '{32'h00000000, 32'hFF800000, 32'h00400000, 32'h00C00000,
    32'h80000000, 32'h82000000, 32'h7F7FFFFF};
  logic [31:0] std_w[7] = '{32'h3F800000, 32'hBF800000, 32'h3FC00000, 32'hBFC00000,
    32'h00000000, 32'h00800000, 32'h7F7FFFFF};
  // standard inputs with the expected native word and class {nan,inf,denorm,zero}
  logic [31:0] in_w[7] = '{32'hBFC00000, 32'h80000000, 32'h00000001, 32'h7F800000,
    32'hFF800000, 32'h7FC00000, 32'h00800000};
  logic [31:0] out_w[7] = '{32'h00C00000, 32'h80000000, 32'h80000000, 32'h7F7FFFFF,
    32'h7F800000, 32'h7F7FFFFF, 32'h82000000};
  logic [3:0] cls_w[7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h4, 4'h8, 4'h0};

  ffc_converter #(.WIDTH(32)) dut (.clk(clk), .rst(rst), .op(op), .src(src),
    .operand_a(operand_a), .operand_b(operand_b), .result(result),
    .result_valid(result_valid), .source_error(source_error), .std_class(std_class));

  // free-running 50 MHz core clock
  always #10 clk = ~clk;

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // valid and error pulses and the held class are compared together since they are read in one cycle
  task chk_flags(input logic v, input logic e, input logic [3:0] c);
    chk({26'h0, result_valid, source_error, std_class}, {26'h0, v, e, c}, "flags");
  endtask

  // op stays up so callers may chain ops back to back; idle drops it a cycle later
  task run(input ffc_op_e o, input ffc_src_e s, input logic [31:0] a, input logic [31:0] b);
    op = o;
    src = s;
    operand_a = a;
    operand_b = b;
    @(posedge clk);
    #2;
  endtask

  task idle;
    op = FFC_OP_NONE;
    @(posedge clk);
    #2;
  endtask

  task t_reset;
    idle;
    chk(result, 32'h00000000, "reset result");
    chk_flags(1'b0, 1'b0, 4'h0);
    $display("test reset done");
  endtask

  // native to standard back to back, alternating source to cover both legal places
  task t_to_std;
    for (int i = 0; i < 7; i++) begin
      run(FFC_OP_TO_STD, (i % 2) ? FFC_SRC_EXTREG : FFC_SRC_MEMORY, nat_w[i], 32'h0);
      chk(result, std_w[i], "to std");
      chk_flags(1'b1, 1'b0, 4'h0);
    end
    idle;
    chk_flags(1'b0, 1'b0, 4'h0);
    $display("test to_std done");
  endtask

  // standard to native, one op at a time so the held result is seen too
  task t_from_std;
    for (int i = 0; i < 7; i++) begin
      run(FFC_OP_FROM_STD, FFC_SRC_MEMORY, in_w[i], 32'h0);
      chk(result, out_w[i], "from std");
      chk_flags(1'b1, 1'b0, cls_w[i]);
      idle;
      chk(result, out_w[i], "held");
    end
    $display("test from_std done");
  endtask

  // a standard operand from a register is refused and leaves the result alone
  task t_src;
    run(FFC_OP_FROM_STD, FFC_SRC_EXTREG, 32'h3F800000, 32'h0);
    chk(result, out_w[6], "refused");
    chk_flags(1'b0, 1'b1, cls_w[6]);
    idle;
    chk_flags(1'b0, 1'b0, cls_w[6]);
    // an undecoded operation code is flagged and changes nothing
    run(ffc_op_e'(5'h03), FFC_SRC_MEMORY, 32'h3F800000, 32'h0);
    chk(result, out_w[6], "illegal op");
    chk_flags(1'b0, 1'b1, cls_w[6]);
    idle;
    chk_flags(1'b0, 1'b0, cls_w[6]);
    $display("test source done");
  endtask

  // signed then unsigned high word back to back on sign-heavy operands
  task t_mul;
    logic [31:0] a[4] = '{32'hFFFFFFFF, 32'h80000000, 32'h12345678, 32'h80000000};
    logic [31:0] b[4] = '{32'hFFFFFFFF, 32'h80000000, 32'h9ABCDEF0, 32'h00000002};
    logic [63:0] p;
    for (int i = 0; i < 4; i++) begin
      p = $signed({{32{a[i][31]}}, a[i]}) * $signed({{32{b[i][31]}}, b[i]});
      run(FFC_OP_MUL_SHI, FFC_SRC_EXTREG, a[i], b[i]);
      chk(result, p[63:32], "signed high");
      chk_flags(1'b1, 1'b0, cls_w[6]);
      p = {32'h0, a[i]} * {32'h0, b[i]};
      run(FFC_OP_MUL_UHI, FFC_SRC_EXTREG, a[i], b[i]);
      chk(result, p[63:32], "unsigned high");
      chk_flags(1'b1, 1'b0, cls_w[6]);
    end
    idle;
    $display("test multiply done");
  endtask

  // a reset in mid-run clears result, flags and class at the same edge
  task t_mid_reset;
    run(FFC_OP_FROM_STD, FFC_SRC_MEMORY, in_w[1], 32'h0);
    rst = 1'b1;
    op = FFC_OP_NONE;
    @(posedge clk);
    #2;
    chk(result, 32'h00000000, "mid reset result");
    chk_flags(1'b0, 1'b0, 4'h0);
    rst = 1'b0;
    t_reset;
  endtask

  task wrap_up;
    $display("compares %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // the whole sequence needs well under 100 cycles
  initial begin
    #20000;
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up;
  end

  initial begin
    repeat (4) @(posedge clk);
    #2;
    rst = 1'b0;
    t_reset;
    t_to_std;
    t_from_std;
    t_src;
    t_mul;
    t_mid_reset;
    wrap_up;
  end
endmodule // test_float_format_converter
